// ---- bidu_defines.svh ----
// constants of the bcd increment/decrement unit
`ifndef BIDU_DEFINES_SVH
`define BIDU_DEFINES_SVH
`define BIDU_OP_INC_SINGLE 10'd594
`define BIDU_OP_INC_DOUBLE 10'd595
`define BIDU_OP_DEC_SINGLE 10'd596
`define BIDU_OP_DEC_DOUBLE 10'd597
`define BIDU_REG_OPERAND_LO 12'h000
`define BIDU_REG_OPERAND_HI 12'h004
`define BIDU_REG_CONTROL 12'h008
`define BIDU_REG_FLAGS 12'h00C
`define BIDU_REG_IRQ_STATUS 12'h010
`define BIDU_REG_IRQ_MASK 12'h014
`define BIDU_CTRL_OPCODE_LSB 0
`define BIDU_CTRL_UPDIFF_BIT 16
`define BIDU_CTRL_COND_BIT 17
`define BIDU_FLAG_ERROR_BIT 0
`define BIDU_FLAG_EQUALS_BIT 1
`define BIDU_FLAG_CARRY_BIT 2
`define BIDU_IRQ_DONE_BIT 0
`define BIDU_IRQ_ERROR_BIT 1
`define BIDU_IRQ_CARRY_BIT 2
`define BIDU_OPCODE_RESET 10'd594
`endif

// ---- bidu_pkg.sv ----
// types of the bcd increment/decrement unit
package bidu_pkg;
  typedef enum logic [1:0] {
    BIDU_IDLE = 2'b00,
    BIDU_EXEC = 2'b01
  } bidu_state_t;
endpackage

// ---- bidu_digit_step.sv ----
// one bcd digit stepped up or down with ripple in and out
`timescale 1ns/1ps
module bidu_digit_step (
  input wire logic [3:0] digit_in,
  input wire logic step_in,
  input wire logic down,
  output logic [3:0] digit_out,
  output logic step_out,
  output logic bad
);
  wire logic wrap_up = (digit_in == 4'h9);
  wire logic wrap_dn = (digit_in == 4'h0);
  wire logic [3:0] inc_val = wrap_up ? 4'h0 : 4'(digit_in + 4'h1);
  wire logic [3:0] dec_val = wrap_dn ? 4'h9 : 4'(digit_in - 4'h1);
  assign bad = (digit_in > 4'h9);
  assign digit_out = !step_in ? digit_in : (down ? dec_val : inc_val);
  assign step_out = step_in & (down ? wrap_dn : wrap_up);
endmodule

// ---- bidu_edge_track.sv ----
// previous-condition bit for the up-differentiated form
`timescale 1ns/1ps
module bidu_edge_track (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scan,
  input wire logic cond,
  output logic rise
);
  logic prev;
  // history advances only on scan edges so a rise spans one scan
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev <= 1'b0;
    end else if (scan) begin
      prev <= cond;
    end
  end
  assign rise = cond & ~prev;
endmodule

// ---- bidu_unit.sv ----
// bcd increment/decrement execution unit with apb registers
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "bidu_defines.svh"
module bidu_unit #(
  parameter int DIGITS = 8
) (
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic SCAN_TICK,
  input wire logic [11:0] PADDR,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic IRQ
);
  generate
    if (DIGITS != 8) begin : g_digits_check
      $error("bidu_unit serves exactly eight digits");
    end
  endgenerate

  logic [15:0] operand_word;
  logic [15:0] operand_hi;
  logic [9:0] opcode;
  logic updiff;
  logic exec_cond;
  logic error_flag;
  logic equals_flag;
  logic carry_flag;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  bidu_pkg::bidu_state_t state;
  bidu_pkg::bidu_state_t next_state;

  wire logic wr = PSEL & PENABLE & PWRITE;
  wire logic rd = PSEL & ~PWRITE;
  wire logic hit_lo = (PADDR == `BIDU_REG_OPERAND_LO);
  wire logic hit_hi = (PADDR == `BIDU_REG_OPERAND_HI);
  wire logic hit_ctl = (PADDR == `BIDU_REG_CONTROL);
  wire logic hit_flg = (PADDR == `BIDU_REG_FLAGS);
  wire logic hit_ist = (PADDR == `BIDU_REG_IRQ_STATUS);
  wire logic hit_imk = (PADDR == `BIDU_REG_IRQ_MASK);
  wire logic mapped = hit_lo | hit_hi | hit_ctl | hit_flg | hit_ist | hit_imk;

  function automatic logic op_valid(input logic [9:0] op);
    op_valid = (op == `BIDU_OP_INC_SINGLE) || (op == `BIDU_OP_INC_DOUBLE) ||
               (op == `BIDU_OP_DEC_SINGLE) || (op == `BIDU_OP_DEC_DOUBLE);
  endfunction

  wire logic is_double = (opcode == `BIDU_OP_INC_DOUBLE) || (opcode == `BIDU_OP_DEC_DOUBLE);
  wire logic is_down = (opcode == `BIDU_OP_DEC_SINGLE) || (opcode == `BIDU_OP_DEC_DOUBLE);

  // digit chain: low word digits 0..3, upper word digits 4..7
  wire logic [31:0] src = {operand_hi, operand_word};
  wire logic [31:0] dst;
  wire logic [DIGITS:0] ripple;
  wire logic [DIGITS-1:0] bad_nib;
  assign ripple[0] = 1'b1;
  genvar g;
  generate
    for (g = 0; g < DIGITS; g++) begin : g_dig
      bidu_digit_step u_step (
        .digit_in(src[4*g+3:4*g]),
        .step_in(ripple[g]),
        .down(is_down),
        .digit_out(dst[4*g+3:4*g]),
        .step_out(ripple[g+1]),
        .bad(bad_nib[g])
      );
    end
  endgenerate

  // single form ignores the upper word for error, carry and equals
  wire logic any_bad = is_double ? (|bad_nib) : (|bad_nib[3:0]);
  wire logic any_wrap = ripple[1];
  wire logic [31:0] result = is_double ? dst : {operand_hi, dst[15:0]};
  wire logic res_zero = is_double ? (result == 32'h0000_0000) : (result[15:0] == 16'h0000);

  wire logic cond_rise;
  bidu_edge_track u_edge (
    .clk(SYS_CLK),
    .rst_n(RESET_N),
    .scan(SCAN_TICK),
    .cond(exec_cond),
    .rise(cond_rise)
  );

  wire logic fire_plain = SCAN_TICK & exec_cond & ~updiff;
  wire logic fire_diff = SCAN_TICK & cond_rise & updiff;
  wire logic fire = (fire_plain | fire_diff) & op_valid(opcode);

  always_comb begin
    next_state = bidu_pkg::BIDU_IDLE;
    case (state)
      bidu_pkg::BIDU_IDLE: next_state = fire ? bidu_pkg::BIDU_EXEC : bidu_pkg::BIDU_IDLE;
      bidu_pkg::BIDU_EXEC: next_state = bidu_pkg::BIDU_IDLE;
      default: next_state = bidu_pkg::BIDU_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state <= bidu_pkg::BIDU_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // operand words: execution has priority over a software write in the same cycle
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      operand_word <= 16'h0000;
      operand_hi <= 16'h0000;
    end else if (fire && !any_bad) begin
      operand_word <= result[15:0];
      operand_hi <= result[31:16];
    end else if (wr && hit_lo) begin
      operand_word <= PWDATA[15:0];
    end else if (wr && hit_hi) begin
      operand_hi <= PWDATA[15:0];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      opcode <= `BIDU_OPCODE_RESET;
      updiff <= 1'b0;
      exec_cond <= 1'b0;
      irq_mask <= 3'h0;
    end else if (wr && hit_ctl) begin
      opcode <= PWDATA[`BIDU_CTRL_OPCODE_LSB +: 10];
      updiff <= PWDATA[`BIDU_CTRL_UPDIFF_BIT];
      exec_cond <= PWDATA[`BIDU_CTRL_COND_BIT];
    end else if (wr && hit_imk) begin
      irq_mask <= PWDATA[2:0];
    end
  end

  // a bad operand touches only the error flag
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      error_flag <= 1'b0;
      equals_flag <= 1'b0;
      carry_flag <= 1'b0;
    end else if (fire) begin
      error_flag <= any_bad;
      if (!any_bad) begin
        equals_flag <= res_zero;
        carry_flag <= any_wrap;
      end
    end
  end

  wire logic [2:0] irq_events = {fire & ~any_bad & any_wrap, fire & any_bad, fire};
  wire logic [2:0] irq_clear = (wr && hit_ist) ? PWDATA[2:0] : 3'h0;
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      irq_status <= 3'h0;
    end else begin
      // set wins over a clear in the same cycle
      irq_status <= (irq_status & ~irq_clear) | irq_events;
    end
  end
  assign IRQ = |(irq_status & irq_mask);

  wire logic [31:0] ctl_rd = {14'h0000, exec_cond, updiff, 6'h00, opcode};
  wire logic [31:0] flg_rd = {29'h0000_0000, carry_flag, equals_flag, error_flag};
  wire logic [31:0] rd_mux = hit_lo ? {16'h0000, operand_word} :
                             hit_hi ? {16'h0000, operand_hi} :
                             hit_ctl ? ctl_rd :
                             hit_flg ? flg_rd :
                             hit_ist ? {29'h0000_0000, irq_status} :
                             hit_imk ? {29'h0000_0000, irq_mask} : 32'h0000_0000;

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PRDATA <= 32'h0000_0000;
    end else if (rd && !PENABLE) begin
      PRDATA <= rd_mux;
    end
  end
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~mapped;

  // checker copy of the scan-sampled condition, kept apart from the edge tracker
  logic cond_at_scan;
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cond_at_scan <= 1'b0;
    end else if (SCAN_TICK) begin
      cond_at_scan <= exec_cond;
    end
  end
  wire logic low_nine = (operand_word[3:0] == 4'h9);
  wire logic low_zero = (operand_word[3:0] == 4'h0);
  wire logic [2:0] wdata_low3 = PWDATA[2:0];

  a_inc_single: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    fire && !any_bad && opcode == `BIDU_OP_INC_SINGLE && !(wr && hit_lo) |=>
    {operand_hi, operand_word} == $past(result))
    else $error("single increment result wrong");
  a_double_carry: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    fire && !any_bad && is_double && operand_word == 16'h9999 |=>
    operand_word == 16'h0000)
    else $error("double step did not ripple");
  a_dec_zero: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    fire && is_down && !is_double && operand_word == 16'h0000 |=>
    operand_word == 16'h9999 && carry_flag)
    else $error("single decrement wrap wrong");
  a_dec_double: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    fire && is_down && is_double && src == 32'h0001_0000 |=>
    operand_hi == 16'h0000 && operand_word == 16'h9999)
    else $error("double decrement borrow wrong");
  a_error_set: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    fire |=> error_flag == $past(any_bad))
    else $error("error flag mismatch");
  a_equals_zero: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    fire && !any_bad |=> equals_flag == $past(res_zero))
    else $error("equals flag mismatch");
  a_carry_inc: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    fire && !any_bad && !is_down |=> carry_flag == $past(low_nine))
    else $error("increment carry mismatch");
  a_carry_dec: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    fire && !any_bad && is_down |=> carry_flag == $past(low_zero))
    else $error("decrement carry mismatch");
  a_plain_each: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    SCAN_TICK && exec_cond && !updiff && op_valid(opcode) |-> fire)
    else $error("plain form missed a scan");
  a_diff_once: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    fire && updiff |-> !cond_at_scan)
    else $error("differentiated form fired twice");
  a_bad_hold: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    fire && any_bad && !wr |=> $stable(operand_word) && $stable(operand_hi) && $stable(carry_flag))
    else $error("bad operand was modified");

  // bus side
  a_ready_high: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    PSEL |-> PREADY)
    else $error("ready dropped");
  a_slverr_unmapped: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    PSEL && PENABLE && !mapped |-> PSLVERR)
    else $error("unmapped access not flagged");
  a_slverr_mapped: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    !(PSEL && PENABLE && !mapped) |-> !PSLVERR)
    else $error("spurious slave error");
  a_rdata_latch: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    rd && !PENABLE |=> PRDATA == $past(rd_mux))
    else $error("read data not latched");
  a_rdata_hold: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    !(rd && !PENABLE) |=> $stable(PRDATA))
    else $error("read data moved");
  a_mask_write: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    wr && hit_imk |=> irq_mask == $past(wdata_low3))
    else $error("mask write lost");
  a_mask_keep: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    !(wr && hit_imk) |=> $stable(irq_mask))
    else $error("mask changed unasked");
  a_ctl_keep: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    !(wr && hit_ctl) |=> $stable(opcode) && $stable(updiff) && $stable(exec_cond))
    else $error("control changed unasked");

  // interrupt side
  a_irq_level: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    IRQ == |(irq_status & irq_mask))
    else $error("interrupt level wrong");
  a_irq_done_set: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    fire |=> irq_status[0])
    else $error("done event lost");
  a_irq_err_set: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    fire && any_bad |=> irq_status[1])
    else $error("error event lost");
  a_irq_cy_set: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    fire && !any_bad && any_wrap |=> irq_status[2])
    else $error("carry event lost");
  a_irq_clear: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    wr && hit_ist && wdata_low3[0] && !fire |=> !irq_status[0])
    else $error("status clear failed");
  a_irq_sticky: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    irq_status[0] && !(wr && hit_ist) |=> irq_status[0])
    else $error("status bit not sticky");
  a_irq_quiet: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    !fire && !(wr && hit_ist) |=> $stable(irq_status))
    else $error("status changed without event");

  // execution side
  a_fire_state: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    fire |=> state == bidu_pkg::BIDU_EXEC)
    else $error("state missed execution");
  a_idle_state: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    !fire |=> state == bidu_pkg::BIDU_IDLE)
    else $error("state left idle");
  a_cond_false: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    SCAN_TICK && !exec_cond |-> !fire)
    else $error("fired with condition false");
  a_no_tick: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    !SCAN_TICK |-> !fire)
    else $error("fired outside a scan");
  a_bad_opcode: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    !op_valid(opcode) |-> !fire)
    else $error("unknown opcode executed");
  a_diff_rise: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    SCAN_TICK && updiff && exec_cond && !cond_at_scan && op_valid(opcode) |-> fire)
    else $error("rise not executed");
  a_rise_prev: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    cond_rise |-> !cond_at_scan)
    else $error("edge history wrong");
  a_ops_hold: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    !fire && !(wr && (hit_lo || hit_hi)) |=> $stable(operand_word) && $stable(operand_hi))
    else $error("operand moved without scan");
  a_flags_hold: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    !fire |=> $stable(error_flag) && $stable(equals_flag) && $stable(carry_flag))
    else $error("flags moved without scan");
  a_step_result: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    fire && !any_bad |=> {operand_hi, operand_word} == $past(result))
    else $error("step result not stored");
  a_single_hi: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    fire && !any_bad && !is_double |=> $stable(operand_hi))
    else $error("single step touched upper word");
  a_err_single: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    fire && !is_double && bad_nib[3:0] == 4'h0 |=> !error_flag)
    else $error("single error from upper word");
  a_err_upper: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    fire && is_double && bad_nib[7:4] != 4'h0 |=> error_flag)
    else $error("double error missed upper word");
  a_inc_nowrap: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    fire && !any_bad && !is_down && !low_nine |=> !carry_flag)
    else $error("increment carry without wrap");
  a_dec_nowrap: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    fire && !any_bad && is_down && !low_zero |=> !carry_flag)
    else $error("decrement carry without wrap");
  a_equals_double: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    fire && is_double && !is_down && src == 32'h9999_9999 |=> equals_flag)
    else $error("double zero result not equal");
endmodule

// ---- bidu_seq_model.sv ----
// scan sequencer model: turns a bench request into a scan tick one cycle later
`timescale 1ns/1ps
module bidu_seq_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic fire,
  output logic tick
);
  // registered so that the tick never shares a cycle with the request edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick <= 1'b0;
    end else begin
      tick <= fire;
    end
  end
endmodule

// ---- bcd_inc_dec_unit_bench.sv ----
// self-checking bench of the bcd increment/decrement unit
`timescale 1ns/1ps
`include "bidu_defines.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module bcd_inc_dec_unit_bench;
  logic sys_clk, reset_n, fire, scan_tick, psel, penable, pwrite, pready, pslverr, irq, last_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, junk;
  int n_fail, compares, cycles;

  bidu_seq_model SEQ (.clk(sys_clk), .rst_n(reset_n), .fire(fire), .tick(scan_tick));
  bidu_unit DUT (.SYS_CLK(sys_clk), .RESET_N(reset_n), .SCAN_TICK(scan_tick), .PADDR(paddr),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq));

  always #5 sys_clk = ~sys_clk;

  task give_verdict;
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // the run should need a few hundred cycles; this ceiling cuts a hang
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      give_verdict();
    end
  end

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge sys_clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) begin
      @(posedge sys_clk);
    end
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, junk);
  endtask

  task rd_chk(input logic [11:0] a, input logic [31:0] e, input string nm);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    `CHK(nm, e, r)
  endtask

  function automatic logic [31:0] ctl(input logic [9:0] opc, input logic ud, input logic c);
    return {14'h0, c, ud, 6'h0, opc};
  endfunction

  task pulse(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      fire <= 1'b1;
      @(posedge sys_clk);
      fire <= 1'b0;
    end
    repeat (2) @(posedge sys_clk);
  endtask

  task chk_op(input logic [9:0] opc, input logic [15:0] lo, input logic [15:0] hi,
              input logic [15:0] elo, input logic [15:0] ehi, input logic [2:0] fl);
    wr(`BIDU_REG_OPERAND_LO, {16'h0, lo});
    wr(`BIDU_REG_OPERAND_HI, {16'h0, hi});
    wr(`BIDU_REG_CONTROL, ctl(opc, 1'b0, 1'b1));
    pulse(1);
    rd_chk(`BIDU_REG_OPERAND_LO, {16'h0, elo}, "low word");
    rd_chk(`BIDU_REG_OPERAND_HI, {16'h0, ehi}, "high word");
    rd_chk(`BIDU_REG_FLAGS, {29'h0, fl}, "flags");
  endtask

  task t_reset;
    `CHK("irq", 1'b0, irq)
    rd_chk(`BIDU_REG_CONTROL, {22'h0, `BIDU_OPCODE_RESET}, "control");
    rd_chk(`BIDU_REG_FLAGS, 32'h0, "flags");
  endtask

  // flags are {carry, equals, error}; a bad operand keeps the earlier equals and carry
  task t_arith;
    chk_op(`BIDU_OP_INC_SINGLE, 16'h0999, 16'h0000, 16'h1000, 16'h0000, 3'h4);
    chk_op(`BIDU_OP_INC_DOUBLE, 16'h9999, 16'h9999, 16'h0000, 16'h0000, 3'h6);
    chk_op(`BIDU_OP_DEC_SINGLE, 16'h1000, 16'h0055, 16'h0999, 16'h0055, 3'h4);
    chk_op(`BIDU_OP_DEC_DOUBLE, 16'h0000, 16'h0001, 16'h9999, 16'h0000, 3'h4);
    chk_op(`BIDU_OP_INC_SINGLE, 16'h0041, 16'h00A0, 16'h0042, 16'h00A0, 3'h0);
    chk_op(`BIDU_OP_INC_DOUBLE, 16'h1234, 16'h00A0, 16'h1234, 16'h00A0, 3'h1);
    chk_op(`BIDU_OP_DEC_SINGLE, 16'h00A5, 16'h0000, 16'h00A5, 16'h0000, 3'h1);
    chk_op(`BIDU_OP_DEC_SINGLE, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 3'h2);
  endtask

  task t_forms;
    wr(`BIDU_REG_OPERAND_LO, 32'h0);
    wr(`BIDU_REG_CONTROL, ctl(`BIDU_OP_INC_SINGLE, 1'b0, 1'b1));
    pulse(3);
    rd_chk(`BIDU_REG_OPERAND_LO, 32'h3, "plain count");
    wr(`BIDU_REG_CONTROL, ctl(`BIDU_OP_INC_SINGLE, 1'b1, 1'b0));
    pulse(1);
    wr(`BIDU_REG_CONTROL, ctl(`BIDU_OP_INC_SINGLE, 1'b1, 1'b1));
    pulse(3);
    rd_chk(`BIDU_REG_OPERAND_LO, 32'h4, "rise count");
    wr(`BIDU_REG_CONTROL, ctl(`BIDU_OP_INC_SINGLE, 1'b1, 1'b0));
    pulse(1);
    wr(`BIDU_REG_CONTROL, ctl(`BIDU_OP_INC_SINGLE, 1'b1, 1'b1));
    pulse(2);
    rd_chk(`BIDU_REG_OPERAND_LO, 32'h5, "second rise");
  endtask

  task t_irq;
    wr(`BIDU_REG_IRQ_MASK, 32'h1);
    @(negedge sys_clk);
    `CHK("irq masked on", 1'b1, irq)
    wr(`BIDU_REG_IRQ_STATUS, 32'h7);
    @(negedge sys_clk);
    `CHK("irq cleared", 1'b0, irq)
    rd_chk(`BIDU_REG_IRQ_STATUS, 32'h0, "status");
    rd_chk(12'h020, 32'h0, "unmapped");
    `CHK("slverr", 1'b1, last_err)
  endtask

  initial begin
    sys_clk = 1'b0;
    reset_n = 1'b0;
    fire = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_reset();
    t_arith();
    t_forms();
    t_irq();
    give_verdict();
  end
endmodule
